// File: hw/buck_cfg.svh
// Purpose: Timing and count constants for the buck PWM control logic.
// Assumes: 40 MHz system clock (25 ns period).
// Notes:   Times are given in their own unit; cycle counts other than DEADTIME_CYCLES are derived from them.
`ifndef BUCK_CFG_SVH
`define BUCK_CFG_SVH
`define CLK_PERIOD_NS      25
`define OSC_PERIOD_NS      1000
`define OSC_CYCLES         (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
`define MAX_DUTY_PCT       94
`define MAX_ON_CYCLES      ((`OSC_CYCLES * `MAX_DUTY_PCT) / 100)
`define SKIP_TON_NS        300
`define SKIP_TON_CYCLES    ((`SKIP_TON_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEADTIME_CYCLES    1
`define SINK_SOFT_PERIODS  32
`define OC_HICCUP_EVENTS   8
`define OC_CLEAR_GOOD      3
`define HICCUP_PERIODS     1024
`endif

// File: hw/buck_pkg.sv
// Purpose: Types shared by the buck PWM control logic.
// Assumes: Flags arrive from comparators, synchronous to clk.
// Notes:   Timing constants live in buck_cfg.svh.
package buck_pkg;
   // Comparator flags from the analog front end
   typedef struct packed {
      logic pwmTrip;      // Error amp crossed current plus slope ramp
      logic hsLimit;      // High-side source current limit (about 5 A)
      logic hsReduced;    // Reduced high-side limit (about 0.4 A)
      logic sinkSoft;     // Low-side sink at -0.4 A
      logic sinkFull;     // Low-side sink at -5 A
      logic zeroCross;    // Inductor current below 200 mA
      logic ssAboveFb;    // Soft-start node above feedback node
      logic ssForce;      // Soft-start node reached 0.58 V
      logic overTemp;     // Over-temperature flag, hysteretic
      logic fbAbovePg;    // Feedback above 555 mV
      logic fbBelowPg;    // Feedback below 527 mV
      logic outAboveSet;  // Output above set point
   } flags_type;

   // Gate and node controls towards the power stage
   typedef struct packed {
      logic hsGate;
      logic lsGate;
      logic ssDischarge;
      logic powerGoodOe;  // Low while pulling power_good_output low
   } drive_type;

   typedef enum logic [2:0] {
      ST_OFF, ST_PREBIAS, ST_HS_ON, ST_LS_ON, ST_RECIRC, ST_HS_BLOCK, ST_IDLE, ST_HICCUP
   } phase_type;
endpackage

// File: hw/gate_deadtime.sv
// Purpose: Break-before-make stage for the two switch gates.
// Assumes: Requests come from the control state machine, never both at once.
// Notes:   A gate turns on only after both gates have been off DEAD cycles.
`timescale 1ns/1ps
`include "buck_cfg.svh"
module gate_deadtime
   import buck_pkg::*;
#(
   parameter int DEAD = `DEADTIME_CYCLES
)
(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic hsReq,
   input  wire logic lsReq,
   output logic      hsGate,
   output logic      lsGate
);
   // Off counter is three bits wide
   if (DEAD < 1 || DEAD > 7)
   begin
      $error("DEAD out of range");
   end

   typedef struct packed {
      logic       hs;
      logic       ls;
      logic [2:0] offCnt;
   } dt_state_type;

   dt_state_type cur_ff;
   dt_state_type nxt_cur;

   // Drop any gate at once; raise one only after dead time with both off
   always_comb
   begin
      nxt_cur = cur_ff;
      if (!hsReq) nxt_cur.hs = 1'b0;
      if (!lsReq) nxt_cur.ls = 1'b0;
      if (cur_ff.hs || cur_ff.ls)
         nxt_cur.offCnt = 3'h0;
      else if (cur_ff.offCnt < 3'(DEAD))
         nxt_cur.offCnt = cur_ff.offCnt + 3'h1;
      if (!cur_ff.hs && !cur_ff.ls && cur_ff.offCnt >= 3'(DEAD))
      begin
         if (hsReq && !lsReq) nxt_cur.hs = 1'b1;
         else if (lsReq && !hsReq) nxt_cur.ls = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cur_ff <= '0;
      else
         cur_ff <= nxt_cur;
   end

   assign hsGate = cur_ff.hs;
   assign lsGate = cur_ff.ls;

   property p_no_overlap;
      @(posedge clk) disable iff (sys_rst) !(hsGate && lsGate);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("gates overlap");

   property p_gap_before_on;
      @(posedge clk) disable iff (sys_rst) $rose(hsGate) |-> $past(!lsGate);
   endproperty
   a_gap_before_on: assert property (p_gap_before_on) else $error("no dead time");
endmodule

// File: hw/buck_pwm_control_logic.sv
// Purpose: Control logic of a synchronous step-down regulator.
// Assumes: All comparator flags synchronous to clk; 40 MHz clock.
// Notes:   Oscillator is a divider; analog loop lives outside.
// Operation
// - High-side on at start of every oscillator cycle in PWM.
// - High-side off when the PWM comparator trips.
// - High-side on-time ends at 94 percent of period at latest.
// - Low-side on for the rest of the cycle after high-side off.
// - Break-before-make, switches never on together.
// - Switching period fixed at 1 MHz.
// - Prebias start holds both off until soft-start crosses feedback.
// - Soft-start at 0.58 V forces switching to start.
// - Sink limit -0.4 A for first 32 periods, then -5 A.
// - Sink limit turns low-side off, high-side on till limit or period end.
// - Reduced high-side limit blocks high-side for rest of period.
// - Power-good released above 555 mV, pulled low below 527 mV.
// - High-side limit turns high-side off and low-side on immediately.
// - Three-bit overcurrent counter counts each limit event.
// - Three clean high-side turn-ons clear the counter.
// - Eight events: discharge soft-start, both off, 1024 periods, restart.
// - Overcurrent counting and hiccup active during soft-start too.
// - Over-temperature stops switching; restart via soft-start when cooled.
// - Skip mode: zero crossing turns low-side off, node high impedance.
// - Skip: next cycle both off if above set point, else 300 ns on.
// - Shutdown holds both switches off.
// - Skip input driven low means normal PWM; an unconnected input has no default.
`timescale 1ns/1ps
`include "buck_cfg.svh"
module buck_pwm_control_logic
   import buck_pkg::*;
#(
   parameter int OSC_CYC   = `OSC_CYCLES,
   parameter int MAXON_CYC = `MAX_ON_CYCLES,
   parameter int SKIPON    = `SKIP_TON_CYCLES,
   parameter int HICCUP    = `HICCUP_PERIODS,
   parameter int SINKSOFT  = `SINK_SOFT_PERIODS
)
(
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire logic      enable,
   input  wire logic      skipSelect,
   input  wire flags_type flags,
   output drive_type      drive,
   output logic           periodStart,
   output logic           hiccupActive,
   output logic [2:0]     ocCount
);
   // Counter widths bound what the logic can serve
   if (OSC_CYC < 4 || OSC_CYC > 64 || MAXON_CYC >= OSC_CYC || SKIPON < 1 || SKIPON >= MAXON_CYC
       || HICCUP < 1 || HICCUP > 1024 || SINKSOFT < 1 || SINKSOFT > 255)
   begin
      $error("bad parameter");
   end

   typedef struct packed {
      phase_type  phase;
      logic [5:0] oscCnt;
      logic [5:0] onCnt;
      logic [2:0] ocCnt;
      logic [1:0] goodCnt;
      logic [7:0] sinkCnt;
      logic [10:0] hicCnt;
      logic       started;    // Switching has begun since soft-start
      logic       hitLimit;   // Cleared when switching starts; nothing sets it
      logic       zcSeen;     // Skip: zero crossing flag, never written
      logic       power_good_output;
   } ctl_state_type;

   ctl_state_type cur_ff;
   ctl_state_type nxt_cur;
   logic          hsReq;
   logic          lsReq;
   logic          osc;
   logic          sinkHit;
   logic          skipMode;
   logic          maxOn;
   logic          running;

   // Fixed-rate oscillator tick
   assign osc      = (cur_ff.oscCnt == 6'(OSC_CYC - 1));
   assign skipMode = skipSelect && enable;
   assign maxOn    = (cur_ff.onCnt >= 6'(MAXON_CYC - 1));
   assign running  = enable && !flags.overTemp;
   // Reduced sink limit first, full one afterwards
   assign sinkHit  = (cur_ff.sinkCnt < 8'(SINKSOFT)) ? flags.sinkSoft : flags.sinkFull;

   always_comb
   begin
      nxt_cur = cur_ff;
      nxt_cur.oscCnt = osc ? 6'h0 : cur_ff.oscCnt + 6'h1;
      if (cur_ff.phase == ST_HS_ON)
         nxt_cur.onCnt = cur_ff.onCnt + 6'h1;
      // Power-good hysteresis
      if (flags.fbAbovePg) nxt_cur.power_good_output = 1'b1;
      else if (flags.fbBelowPg) nxt_cur.power_good_output = 1'b0;
      if (osc && cur_ff.started && cur_ff.sinkCnt < 8'(SINKSOFT))
         nxt_cur.sinkCnt = cur_ff.sinkCnt + 8'h1;

      unique case (cur_ff.phase)
         ST_OFF:
            nxt_cur.phase = ST_PREBIAS;
         ST_PREBIAS:
            // Both off until soft-start passes feedback or forced level
            if (osc && (flags.ssAboveFb || flags.ssForce))
            begin
               nxt_cur.started = 1'b1;
               nxt_cur.phase   = ST_HS_ON;
               nxt_cur.onCnt   = 6'h0;
               nxt_cur.hitLimit = 1'b0;
            end
         ST_HS_ON:
            if (flags.hsLimit)
            begin
               nxt_cur.phase = ST_LS_ON;
               nxt_cur.goodCnt = 2'h0;
               if (cur_ff.ocCnt == 3'(`OC_HICCUP_EVENTS - 1))
               begin
                  nxt_cur.phase  = ST_HICCUP;
                  nxt_cur.hicCnt = 11'h0;
               end
               nxt_cur.ocCnt = cur_ff.ocCnt + 3'h1;
            end
            else if ((!skipMode && (flags.pwmTrip || maxOn)) ||
                     (skipMode && cur_ff.onCnt >= 6'(SKIPON - 1)) || osc)
            begin
               nxt_cur.phase = ST_LS_ON;
               if (cur_ff.goodCnt == 2'(`OC_CLEAR_GOOD - 1))
               begin
                  nxt_cur.ocCnt   = 3'h0;
                  nxt_cur.goodCnt = 2'h0;
               end
               else
                  nxt_cur.goodCnt = cur_ff.goodCnt + 2'h1;
            end
         ST_LS_ON, ST_IDLE:
            // Period start decides first, so a late event never costs a whole period
            if (osc && (!skipMode || !flags.outAboveSet))
            begin
               nxt_cur.phase = ST_HS_ON;
               nxt_cur.onCnt = 6'h0;
            end
            else if (osc)
               nxt_cur.phase = ST_IDLE;
            else if (cur_ff.phase == ST_LS_ON && sinkHit && !skipMode)
               nxt_cur.phase = ST_RECIRC;
            else if (cur_ff.phase == ST_LS_ON && skipMode && flags.zeroCross)
               nxt_cur.phase = ST_IDLE;
         ST_RECIRC:
            if (osc)
            begin
               nxt_cur.phase = ST_HS_ON;
               nxt_cur.onCnt = 6'h0;
            end
            else if (flags.hsReduced)
               nxt_cur.phase = ST_HS_BLOCK;
         ST_HS_BLOCK:
            if (osc)
            begin
               nxt_cur.phase = ST_HS_ON;
               nxt_cur.onCnt = 6'h0;
            end
         ST_HICCUP:
            // Wait the hiccup timeout counted in oscillator periods
            if (osc)
            begin
               if (cur_ff.hicCnt == 11'(HICCUP - 1))
               begin
                  nxt_cur.phase   = ST_PREBIAS;
                  nxt_cur.ocCnt   = 3'h0;
                  nxt_cur.started = 1'b0;
                  nxt_cur.sinkCnt = 8'h0;
               end
               else
                  nxt_cur.hicCnt = cur_ff.hicCnt + 11'h1;
            end
      endcase

      // Shutdown and thermal stop restart through soft-start
      if (!enable || flags.overTemp)
      begin
         nxt_cur.phase   = ST_OFF;
         nxt_cur.ocCnt   = 3'h0;
         nxt_cur.goodCnt = 2'h0;
         nxt_cur.sinkCnt = 8'h0;
         nxt_cur.hicCnt  = 11'h0;
         nxt_cur.started = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cur_ff <= '{phase: ST_OFF, default: '0};
      else
         cur_ff <= nxt_cur;
   end

   // Gate requests per phase
   always_comb
   begin
      hsReq = (cur_ff.phase == ST_HS_ON) || (cur_ff.phase == ST_RECIRC);
      lsReq = (cur_ff.phase == ST_LS_ON) || (cur_ff.phase == ST_HS_BLOCK);
   end

   gate_deadtime #(.DEAD(`DEADTIME_CYCLES)) u_dead
   (
      .clk     (clk),
      .sys_rst (sys_rst),
      .hsReq   (hsReq),
      .lsReq   (lsReq),
      .hsGate  (drive.hsGate),
      .lsGate  (drive.lsGate)
   );

   // Soft-start discharge while off or in hiccup; power-good open drain
   assign drive.ssDischarge = (cur_ff.phase == ST_HICCUP) || (cur_ff.phase == ST_OFF);
   assign drive.powerGoodOe = cur_ff.power_good_output;
   assign periodStart       = osc;
   assign hiccupActive      = (cur_ff.phase == ST_HICCUP);
   assign ocCount           = cur_ff.ocCnt;

   property p_maxon;
      @(posedge clk) disable iff (sys_rst) cur_ff.phase == ST_HS_ON |-> cur_ff.onCnt < 6'(MAXON_CYC);
   endproperty
   a_maxon: assert property (p_maxon) else $error("on-time past max duty");

   property p_limit_off;
      @(posedge clk) disable iff (sys_rst)
         cur_ff.phase == ST_HS_ON && flags.hsLimit && enable && !flags.overTemp |=> !hsReq;
   endproperty
   a_limit_off: assert property (p_limit_off) else $error("limit did not end on-time");

   property p_count;
      @(posedge clk) disable iff (sys_rst)
         cur_ff.phase == ST_HS_ON && flags.hsLimit && enable && !flags.overTemp && cur_ff.ocCnt != 3'h7
         |=> ocCount == $past(ocCount) + 3'h1;
   endproperty
   a_count: assert property (p_count) else $error("counter missed event");

   property p_hiccup_off;
      @(posedge clk) disable iff (sys_rst) hiccupActive |-> !hsReq && !lsReq && drive.ssDischarge;
   endproperty
   a_hiccup_off: assert property (p_hiccup_off) else $error("switching in hiccup");

   property p_shutdown;
      @(posedge clk) disable iff (sys_rst) !enable |=> ##1 !drive.hsGate && !drive.lsGate && ocCount == 3'h0;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("switch on while shut down");

   property p_thermal;
      @(posedge clk) disable iff (sys_rst) flags.overTemp |=> cur_ff.phase == ST_OFF;
   endproperty
   a_thermal: assert property (p_thermal) else $error("no thermal stop");

   property p_power_good_output;
      @(posedge clk) disable iff (sys_rst) flags.fbAbovePg |=> drive.powerGoodOe;
   endproperty
   a_power_good_output: assert property (p_power_good_output) else $error("power good not released");

   property p_prebias;
      @(posedge clk) disable iff (sys_rst) cur_ff.phase == ST_PREBIAS |-> !hsReq && !lsReq;
   endproperty
   a_prebias: assert property (p_prebias) else $error("switching in prebias");

   property p_skip_zc;
      @(posedge clk) disable iff (sys_rst)
         skipMode && cur_ff.phase == ST_LS_ON && flags.zeroCross && enable && !flags.overTemp |=> !lsReq;
   endproperty
   a_skip_zc: assert property (p_skip_zc) else $error("low side kept after zero crossing");

   property p_pwm_start;
      @(posedge clk) disable iff (sys_rst)
         osc && running && !skipMode && cur_ff.phase inside {ST_LS_ON, ST_IDLE, ST_RECIRC, ST_HS_BLOCK}
         |=> cur_ff.phase == ST_HS_ON;
   endproperty
   a_pwm_start: assert property (p_pwm_start) else $error("period start missed");

   property p_sink_recirc;
      @(posedge clk) disable iff (sys_rst)
         cur_ff.phase == ST_LS_ON && sinkHit && !skipMode && !osc && running |=> hsReq && !lsReq;
   endproperty
   a_sink_recirc: assert property (p_sink_recirc) else $error("sink limit kept low side on");

   property p_reduced_block;
      @(posedge clk) disable iff (sys_rst)
         cur_ff.phase == ST_RECIRC && flags.hsReduced && !osc && running |=> !hsReq;
   endproperty
   a_reduced_block: assert property (p_reduced_block) else $error("reduced limit kept high side on");

   property p_hiccup_entry;
      @(posedge clk) disable iff (sys_rst)
         cur_ff.phase == ST_HS_ON && flags.hsLimit && running && cur_ff.ocCnt == 3'(`OC_HICCUP_EVENTS - 1)
         |=> hiccupActive;
   endproperty
   a_hiccup_entry: assert property (p_hiccup_entry) else $error("eighth event missed hiccup");

   property p_power_good_output_low;
      @(posedge clk) disable iff (sys_rst) flags.fbBelowPg && !flags.fbAbovePg |=> !drive.powerGoodOe;
   endproperty
   a_power_good_output_low: assert property (p_power_good_output_low) else $error("power good not pulled low");

   property p_skip_idle;
      @(posedge clk) disable iff (sys_rst)
         osc && skipMode && flags.outAboveSet && running && cur_ff.phase inside {ST_LS_ON, ST_IDLE}
         |=> !hsReq && !lsReq;
   endproperty
   a_skip_idle: assert property (p_skip_idle) else $error("skip switched above set point");

   c_hiccup: cover property (@(posedge clk) disable iff (sys_rst) $rose(hiccupActive));
   c_recirc: cover property (@(posedge clk) disable iff (sys_rst) cur_ff.phase == ST_RECIRC);
   c_skip:   cover property (@(posedge clk) disable iff (sys_rst) cur_ff.phase == ST_IDLE);
   c_power_good_output:  cover property (@(posedge clk) disable iff (sys_rst) $rose(drive.powerGoodOe));
endmodule

// File: tb/power_stage_model.sv
// Purpose: Behavioural power stage with its current comparators.
// Assumes: Gates active high; counts advance on the rising edge of clk.
// Notes:   Trip, limit and zero cross follow the gate on-time, so answers come late or early on demand.
`timescale 1ns/1ps
module power_stage_model
(
   input  wire logic       clk,
   input  wire logic       hsGate,
   input  wire logic       lsGate,
   input  wire logic [7:0] tripAt,
   input  wire logic       limitMode,
   input  wire logic [7:0] zcAt,
   output logic            pwmTrip,
   output logic            hsLimit,
   output logic            zeroCross,
   output int              overlaps
);
   int hsCnt = 0;
   int lsCnt = 0;
   int shootCnt = 0;

   // Inductor current ramps while a gate is held on; shoot-through is counted
   always @(posedge clk)
   begin
      hsCnt <= hsGate ? hsCnt + 1 : 0;
      lsCnt <= lsGate ? lsCnt + 1 : 0;
      if (hsGate && lsGate)
         shootCnt <= shootCnt + 1;
   end

   assign overlaps = shootCnt;

   // Comparator outputs fall on the first clock edge after the gate that feeds them drops
   assign pwmTrip   = !limitMode && hsCnt >= tripAt;
   assign hsLimit   = limitMode && hsCnt >= 3;
   assign zeroCross = lsCnt >= zcAt;
endmodule

// File: tb/testbench.sv
// Purpose: Self-checking bench for the buck PWM control logic.
// Assumes: Flags change 2 ns after the rising edge; 40 MHz clock.
// Notes:   Hiccup wait shortened to 4 periods and the soft sink window to 2.
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, (e) === (g), 32'(e), 32'(g))
module testbench;
   import buck_pkg::*;
   logic       clk = 0;
   logic       sys_rst = 1;
   logic       enable = 0;
   logic       skipSelect = 0;
   flags_type  benchFlags = '0;
   flags_type  flags;
   drive_type  drive;
   logic       periodStart, hiccupActive, pwmTrip, hsLimit, zeroCross, lsAtEnd;
   logic [2:0] ocCount;
   logic [7:0] tripAt = 8'h0A;
   logic [7:0] zcAt = 8'hC8;
   logic       limitMode = 0;
   int         overlaps, numErrors = 0, nChecks = 0, cycles = 0, hsOn, ticks;

   buck_pwm_control_logic #(.HICCUP(4), .SINKSOFT(2)) buck_pwm_control_logic_i (.clk(clk), .sys_rst(sys_rst),
      .enable(enable), .skipSelect(skipSelect), .flags(flags), .drive(drive), .periodStart(periodStart),
      .hiccupActive(hiccupActive), .ocCount(ocCount));
   power_stage_model power_stage_model_i (.clk(clk), .hsGate(drive.hsGate), .lsGate(drive.lsGate), .tripAt(tripAt),
      .limitMode(limitMode), .zcAt(zcAt), .pwmTrip(pwmTrip), .hsLimit(hsLimit), .zeroCross(zeroCross),
      .overlaps(overlaps));

   // Model comparators override the bench-held flags
   always_comb
   begin
      flags           = benchFlags;
      flags.pwmTrip   = pwmTrip;
      flags.hsLimit   = hsLimit;
      flags.zeroCross = zeroCross;
   end

   always #12.5 clk = ~clk;

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         numErrors++;
         end_sim();
      end
   end

   task automatic check(string nm, logic ok, logic [31:0] e, logic [31:0] g);
      nChecks++;
      if (ok !== 1'h1)
      begin
         numErrors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic tick();
      @(posedge clk);
      #2;
   endtask

   // One oscillator period from the period start at hand, or the next one
   task automatic measure();
      ticks = 0;
      while (periodStart !== 1'h1 && ticks < 60)
      begin
         tick();
         ticks++;
      end
      hsOn = 0;
      ticks = 0;
      do
      begin
         tick();
         ticks++;
         hsOn += drive.hsGate;
      end
      while (periodStart !== 1'h1 && ticks < 60);
      lsAtEnd = drive.lsGate;
   endtask

   task automatic test_prebias();
      enable = 1;
      repeat (3) measure();
      `CHK("prebias hs", 0, hsOn);
      `CHK("prebias ls", 1'h0, lsAtEnd);
      benchFlags.ssForce = 1'h1;
      repeat (2) measure();
      `CHK("forced start", 1'h1, 32'(hsOn > 0));
   endtask

   task automatic test_pwm();
      measure();
      `CHK("period", 40, ticks);
      `CHK("trip on-time", 1'h1, 32'(hsOn >= 10 && hsOn <= 13));
      `CHK("ls to end", 1'h1, lsAtEnd);
      tripAt = 8'hC8;
      measure();
      `CHK("max duty", 1'h1, 32'(hsOn >= 30 && hsOn <= 37));
      tripAt = 8'h0A;
      benchFlags.sinkSoft = 1'h1;
      benchFlags.sinkFull = 1'h1;
      repeat (2) measure();
      `CHK("sink ls off", 1'h0, lsAtEnd);
      `CHK("recirc hs", 1'h1, drive.hsGate);
      benchFlags.hsReduced = 1'h1;
      measure();
      `CHK("reduced hs", 1'h0, drive.hsGate);
      benchFlags = '0;
      benchFlags.ssForce = 1'h1;
      repeat (2) measure();
   endtask

   task automatic test_hiccup();
      limitMode = 1;
      for (int i = 1; i < 8; i++)
      begin
         measure();
         `CHK("ocCount", i, ocCount);
         `CHK("limit ls on", 1'h1, lsAtEnd);
         `CHK("limit on-time", 1'h1, 32'(hsOn >= 3 && hsOn <= 6));
      end
      ticks = 0;
      while (hiccupActive !== 1'h1 && ticks < 80)
      begin
         tick();
         ticks++;
      end
      `CHK("discharge", 1'h1, drive.ssDischarge);
      ticks = 0;
      hsOn = 0;
      while (hiccupActive === 1'h1 && ticks < 400)
      begin
         tick();
         ticks++;
         hsOn += drive.hsGate + drive.lsGate;
      end
      `CHK("hiccup wait", 1'h1, 32'(ticks >= 150 && ticks <= 170));
      `CHK("hiccup gates", 0, hsOn);
      limitMode = 0;
      repeat (5) measure();
      `CHK("restart", 1'h1, 32'(hsOn > 0));
      limitMode = 1;
      measure();
      limitMode = 0;
      `CHK("one event", 3'h1, ocCount);
      repeat (2) measure();
      `CHK("two clean", 3'h1, ocCount);
      measure();
      `CHK("three clean", 3'h0, ocCount);
   endtask

   task automatic test_power_good();
      benchFlags.fbAbovePg = 1'h1;
      repeat (3) tick();
      benchFlags.fbAbovePg = 1'h0;
      repeat (3) tick();
      `CHK("pg released", 1'h1, drive.powerGoodOe);
      benchFlags.fbBelowPg = 1'h1;
      repeat (3) tick();
      benchFlags.fbBelowPg = 1'h0;
      tick();
      `CHK("pg pulled", 1'h0, drive.powerGoodOe);
   endtask

   task automatic test_thermal();
      benchFlags.overTemp = 1'h1;
      repeat (4) tick();
      measure();
      `CHK("hot hs", 0, hsOn);
      `CHK("hot ls", 1'h0, lsAtEnd);
      benchFlags.overTemp = 1'h0;
      repeat (3) measure();
      `CHK("cool restart", 1'h1, 32'(hsOn > 0));
   endtask

   task automatic test_skip();
      skipSelect = 1;
      zcAt = 8'h05;
      tripAt = 8'hC8;
      repeat (2) measure();
      `CHK("skip on-time", 1'h1, 32'(hsOn >= 11 && hsOn <= 13));
      `CHK("skip ls off", 1'h0, lsAtEnd);
      benchFlags.outAboveSet = 1'h1;
      repeat (2) measure();
      `CHK("skip idle", 0, hsOn);
      benchFlags.outAboveSet = 1'h0;
      // Zero cross stays early, so only plain PWM keeps the low side to the end
      skipSelect = 0;
      tripAt = 8'h0A;
      repeat (2) measure();
      `CHK("pwm again", 1'h1, lsAtEnd);
      zcAt = 8'hC8;
   endtask

   task automatic test_disable();
      limitMode = 1;
      measure();
      limitMode = 0;
      enable = 0;
      benchFlags.ssForce = 1'h0;
      repeat (3) tick();
      `CHK("off ocCount", 3'h0, ocCount);
      `CHK("off gates", 2'h0, {drive.hsGate, drive.lsGate});
      `CHK("off discharge", 1'h1, drive.ssDischarge);
      enable = 1;
      repeat (2) measure();
      `CHK("fresh prebias", 0, hsOn);
      // Reduced sink limit binds only in the first periods after a fresh start
      benchFlags.ssAboveFb = 1'h1;
      benchFlags.sinkSoft = 1'h1;
      measure();
      `CHK("ss crosses fb", 1'h1, 32'(hsOn > 0));
      `CHK("soft sink", 1'h0, lsAtEnd);
      repeat (2) measure();
      `CHK("soft sink over", 1'h1, lsAtEnd);
   endtask

   task automatic end_sim();
      $display("Checks %0d mismatches %0d", nChecks, numErrors);
      if (numErrors == 0 && nChecks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (8) tick();
      `CHK("rst gates", 2'h0, {drive.hsGate, drive.lsGate});
      `CHK("rst discharge", 1'h1, drive.ssDischarge);
      `CHK("rst pg", 1'h0, drive.powerGoodOe);
      `CHK("rst ocCount", 3'h0, ocCount);
      sys_rst = 0;
      test_prebias();
      test_pwm();
      test_hiccup();
      test_power_good();
      test_thermal();
      test_skip();
      test_disable();
      `CHK("overlap", 0, overlaps);
      end_sim();
   end
endmodule
